// File: hdl/serial_flash_command_decoder.v
// Command decoder for a serial NOR flash on a single, dual or quad link.
`timescale 1ns/10ps
`default_nettype none
`include "sflash_consts.vh"

module serial_flash_command_decoder #(
  parameter [7:0] MFR_ID   = 8'h5A,  // Arbitrary value.
  parameter [7:0] MEM_TYPE = 8'h3C,  // Arbitrary value.
  parameter [7:0] MEM_CAP  = 8'h15   // Arbitrary value.
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        sck_pin,
  input  wire        cs_n_pin,
  input  wire [3:0]  dq_in,
  output reg  [3:0]  dq_out,
  output reg  [3:0]  dq_oe,
  input  wire        busy_in,
  input  wire        op_done,
  input  wire [5:0]  nv_status,
  input  wire        deep_pd,
  input  wire [7:0]  mem_rd_data,
  output reg         mem_rd_req,
  output reg  [23:0] mem_rd_addr,
  output reg         op_start,
  output reg  [7:0]  op_code,
  output reg  [23:0] op_addr,
  output reg  [7:0]  wr_byte,
  output reg         wr_byte_valid,
  output reg         abort,
  output reg         quad_command_mode,
  output reg         enhanced,
  output reg         otp_mode,
  output reg         write_enable_latch,
  output reg         reset_busy
);

  localparam [2:0] PH_CMD   = 3'd0;
  localparam [2:0] PH_ADDR  = 3'd1;
  localparam [2:0] PH_DUMMY = 3'd2;
  localparam [2:0] PH_OUT   = 3'd3;
  localparam [2:0] PH_DIN   = 3'd4;
  localparam [2:0] PH_END   = 3'd5;
  localparam [2:0] PH_IGN   = 3'd6;
  localparam [1:0] SRC_MEM  = 2'd0;
  localparam [1:0] SRC_STAT = 2'd1;
  localparam [1:0] SRC_ID   = 2'd2;
  localparam [31:0] RECOV_FULL = `RST_RECOV_CYC;
  localparam [11:0] RECOV_CYC  = RECOV_FULL[11:0];  // Fits in 12 bits.

  wire [5:0] pins_s;
  wire       sck_s  = pins_s[5];
  wire       cs_n_s = pins_s[4];
  wire [3:0] dq_s   = pins_s[3:0];

  reg        sck_d_ff;
  reg        cs_d_ff;
  reg [2:0]  ph_ff;
  reg [7:0]  op_ff;
  reg [23:0] sh_ff;
  reg [5:0]  cnt_ff;
  reg [2:0]  iw_ff;
  reg [2:0]  ow_ff;
  reg [3:0]  dcnt_ff;
  reg [7:0]  ind_ff;
  reg [1:0]  src_ff;
  reg [7:0]  obyte_ff;
  reg [3:0]  opos_ff;
  reg [7:0]  pre_ff;
  reg        req_d_ff;
  reg [1:0]  id_idx_ff;
  reg        got_data_ff;
  reg        arm_ff;
  reg        vol_arm_ff;
  reg        vol_ovr_ff;
  reg [5:0]  vol_ff;
  reg [11:0] rcv_ff;

  // Cs resets to deselected so no frame is seen while the pins settle.
  pin_sync #(.W(6), .RST_VAL(6'h10)) u_pin_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d_in     ({sck_pin, cs_n_pin, dq_in}),
    .q_out    (pins_s)
  );

  // Edges of the filtered serial clock count only inside a frame.
  wire sck_rise    = sck_s & ~sck_d_ff & ~cs_n_s;
  wire sck_fall    = ~sck_s & sck_d_ff & ~cs_n_s;
  wire frame_start = ~cs_n_s & cs_d_ff;
  wire frame_end   = cs_n_s & ~cs_d_ff;

  // Shift in one, two or four bits per rising edge, high bit line first.
  wire [23:0] nsh  = (iw_ff == 3'd4) ? {sh_ff[19:0], dq_s} :
                     (iw_ff == 3'd2) ? {sh_ff[21:0], dq_s[1:0]} :
                                       {sh_ff[22:0], dq_s[0]};
  wire [5:0]  ncnt = cnt_ff + {3'b000, iw_ff};
  wire [7:0]  nbyte = nsh[7:0];

  wire is_prog  = (op_ff == `OP_PP) | (op_ff == `OP_QPP);
  wire is_erase = (op_ff == `OP_SE) | (op_ff == `OP_HBE) |
                  (op_ff == `OP_BE);
  wire is_ce    = (op_ff == `OP_CE1) | (op_ff == `OP_CE2);
  wire enh_frame_cmd = (nbyte == `OP_QEXIT) | (nbyte == `OP_RARM) |
                       (nbyte == `OP_REXEC);

  // Status byte: volatile copy when written, else the stored bits.
  wire [5:0] sr_hi   = vol_ovr_ff ? vol_ff : nv_status;
  wire [7:0] sr_byte = {sr_hi, write_enable_latch, busy_in};
  wire [7:0] id_byte = (id_idx_ff == 2'd0) ? MFR_ID :
                       (id_idx_ff == 2'd1) ? MEM_TYPE : MEM_CAP;
  wire [7:0] src_byte = (src_ff == SRC_STAT) ? sr_byte :
                        (src_ff == SRC_ID) ? id_byte : pre_ff;
  wire [7:0] cur_byte = (opos_ff == 4'd0) ? src_byte : obyte_ff;

  // Opcode decode: next phase, widths, dummy count and byte source.
  reg [2:0] d_ph;
  reg [2:0] d_aw;
  reg [2:0] d_ow;
  reg [3:0] d_dum;
  reg [1:0] d_src;
  always @* begin
    d_ph  = PH_END;
    d_aw  = quad_command_mode ? 3'd4 : 3'd1;
    d_ow  = quad_command_mode ? 3'd4 : 3'd1;
    d_dum = 4'd0;
    d_src = SRC_MEM;
    case (nbyte)
      `OP_READ: d_ph = PH_ADDR;
      `OP_FAST: begin
        d_ph  = PH_ADDR;
        d_dum = quad_command_mode ? `DUM_QUAD : `DUM_SINGLE;
      end
      `OP_DOUT: begin
        d_ph  = PH_ADDR;
        d_ow  = 3'd2;
        d_dum = `DUM_SINGLE;
      end
      `OP_DIO: begin
        d_ph  = PH_ADDR;
        d_aw  = 3'd2;
        d_ow  = 3'd2;
        d_dum = `DUM_DIO;
      end
      `OP_QOUT: begin
        d_ph  = PH_ADDR;
        d_ow  = 3'd4;
        d_dum = `DUM_SINGLE;
      end
      `OP_QIO: begin
        d_ph  = PH_ADDR;
        d_aw  = 3'd4;
        d_ow  = 3'd4;
        d_dum = `DUM_QIO;
      end
      `OP_STATUS_READ_CMD: begin
        d_ph  = PH_OUT;
        d_src = SRC_STAT;
      end
      `OP_RDID: begin
        d_ph  = PH_OUT;
        d_src = SRC_ID;
      end
      `OP_STATUS_WRITE_CMD: d_ph = PH_DIN;
      `OP_PP, `OP_QPP, `OP_SE, `OP_HBE, `OP_BE: d_ph = PH_ADDR;
      `OP_CE1, `OP_CE2, `OP_WRITE_ENABLE_CMD, `OP_WRITE_DISABLE_CMD, `OP_VWREN, `OP_QENTRY,
      `OP_QEXIT, `OP_RARM, `OP_REXEC, `OP_OTP: d_ph = PH_END;
      default: d_ph = PH_IGN;
    endcase
    // Quad command mode refuses the single-mode-only opcodes.
    if (quad_command_mode && ((nbyte == `OP_READ) || (nbyte == `OP_DOUT) ||
        (nbyte == `OP_DIO) || (nbyte == `OP_QPP) || (nbyte == `OP_QOUT)))
      d_ph = PH_IGN;
    // Array reads other than enhanced frames are ignored while an internal cycle runs.
    if (busy_in && (d_ph == PH_ADDR) && (d_dum != 4'd0 ||
        nbyte == `OP_READ))
      d_ph = PH_IGN;
  end

  // Frame engine: shifts command, address, dummy and data phases.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_d_ff      <= 1'b0;
      cs_d_ff       <= 1'b1;
      ph_ff         <= PH_IGN;
      op_ff         <= 8'h00;
      sh_ff         <= 24'h00_0000;
      cnt_ff        <= 6'd0;
      iw_ff         <= 3'd1;
      ow_ff         <= 3'd1;
      dcnt_ff       <= 4'd0;
      ind_ff        <= 8'h00;
      src_ff        <= SRC_MEM;
      obyte_ff      <= 8'h00;
      opos_ff       <= 4'd0;
      pre_ff        <= 8'h00;
      req_d_ff      <= 1'b0;
      id_idx_ff     <= 2'd0;
      got_data_ff   <= 1'b0;
      dq_out        <= 4'h0;
      dq_oe         <= 4'h0;
      mem_rd_req    <= 1'b0;
      mem_rd_addr   <= 24'h00_0000;
      op_addr       <= 24'h00_0000;
      wr_byte       <= 8'h00;
      wr_byte_valid <= 1'b0;
    end else begin
      sck_d_ff      <= sck_s;
      cs_d_ff       <= cs_n_s;
      mem_rd_req    <= 1'b0;
      wr_byte_valid <= 1'b0;
      req_d_ff      <= mem_rd_req;
      if (req_d_ff)
        pre_ff <= mem_rd_data;
      if (frame_start) begin
        // An enhanced read frame starts straight with the quad address.
        ph_ff       <= (rcv_ff != 12'd0) ? PH_IGN :
                       enhanced ? PH_ADDR : PH_CMD;
        op_ff       <= enhanced ? `OP_QIO : 8'h00;
        iw_ff       <= (enhanced || quad_command_mode) ? 3'd4 : 3'd1;
        ow_ff       <= 3'd4;
        dcnt_ff     <= `DUM_QIO;
        sh_ff       <= 24'h00_0000;
        cnt_ff      <= 6'd0;
        ind_ff      <= 8'h00;
        opos_ff     <= 4'd0;
        id_idx_ff   <= 2'd0;
        got_data_ff <= 1'b0;
      end else if (frame_end) begin
        dq_oe <= 4'h0;
      end else if (sck_rise) begin
        sh_ff  <= nsh;
        cnt_ff <= ncnt;
        case (ph_ff)
          PH_CMD: begin
            if (ncnt == `BYTE_BITS) begin
              op_ff   <= nbyte;
              ph_ff   <= d_ph;
              iw_ff   <= (nbyte == `OP_QPP) ? 3'd4 : d_aw;
              ow_ff   <= d_ow;
              dcnt_ff <= d_dum;
              src_ff  <= d_src;
              cnt_ff  <= 6'd0;
            end
          end
          PH_ADDR: begin
            if (enhanced && (ncnt == `BYTE_BITS) && enh_frame_cmd) begin
              op_ff <= nbyte;
              ph_ff <= PH_END;
            end else if (ncnt == `ADDR_BITS) begin
              cnt_ff <= 6'd0;
              src_ff <= SRC_MEM;
              if (is_prog) begin
                op_addr <= nsh;
                ph_ff   <= PH_DIN;
                iw_ff   <= (op_ff == `OP_QPP) ? 3'd4 : iw_ff;
              end else if (is_erase) begin
                op_addr <= nsh;
                ph_ff   <= PH_END;
              end else begin
                mem_rd_addr <= nsh;
                mem_rd_req  <= 1'b1;
                ph_ff       <= (dcnt_ff == 4'd0) ? PH_OUT : PH_DUMMY;
              end
            end
          end
          PH_DUMMY: begin
            // The leading dummy clocks of the quad read carry the indicator.
            if (op_ff == `OP_QIO && dcnt_ff > `DUM_QIO - `IND_CLKS)
              ind_ff <= {ind_ff[3:0], dq_s};
            dcnt_ff <= dcnt_ff - 4'd1;
            if (dcnt_ff == 4'd1)
              ph_ff <= PH_OUT;
          end
          PH_DIN: begin
            if (ncnt == `BYTE_BITS) begin
              cnt_ff      <= 6'd0;
              got_data_ff <= 1'b1;
              if (op_ff == `OP_STATUS_WRITE_CMD) begin
                wr_byte <= nbyte;
                ph_ff   <= PH_END;
              end else if (write_enable_latch && !busy_in) begin
                wr_byte       <= nbyte;
                wr_byte_valid <= 1'b1;
              end
            end
          end
          PH_OUT: ph_ff <= PH_OUT;
          // Stray clocks after a complete command void it.
          PH_END: ph_ff <= PH_IGN;
          default: ph_ff <= PH_IGN;
        endcase
      end else if (sck_fall && ph_ff == PH_OUT) begin
        // New byte when the last is spent; memory prefetches the next.
        if (opos_ff == 4'd0) begin
          opos_ff <= 4'd8 - {1'b0, ow_ff};
          if (src_ff == SRC_MEM) begin
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= mem_rd_addr + 24'h00_0001;
          end
          if (src_ff == SRC_ID)
            id_idx_ff <= (id_idx_ff == 2'd2) ? 2'd0 : id_idx_ff + 2'd1;
        end else begin
          opos_ff <= opos_ff - {1'b0, ow_ff};
        end
        obyte_ff <= (ow_ff == 3'd4) ? {cur_byte[3:0], 4'h0} :
                    (ow_ff == 3'd2) ? {cur_byte[5:0], 2'b00} :
                                      {cur_byte[6:0], 1'b0};
        // Single width drives the data-out line only.
        case (ow_ff)
          3'd4: begin
            dq_out <= cur_byte[7:4];
            dq_oe  <= 4'hF;
          end
          3'd2: begin
            dq_out <= {2'b00, cur_byte[7:6]};
            dq_oe  <= 4'h3;
          end
          default: begin
            dq_out <= {2'b00, cur_byte[7], 1'b0};
            dq_oe  <= 4'h2;
          end
        endcase
      end
    end
  end

  // Commit at deselect: mode changes, latches, resets and array starts.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quad_command_mode  <= 1'b0;
      enhanced           <= 1'b0;
      otp_mode           <= 1'b0;
      write_enable_latch <= 1'b0;
      arm_ff             <= 1'b0;
      vol_arm_ff         <= 1'b0;
      vol_ovr_ff         <= 1'b0;
      vol_ff             <= 6'h00;
      rcv_ff             <= 12'd0;
      reset_busy         <= 1'b0;
      abort              <= 1'b0;
      op_start           <= 1'b0;
      op_code            <= 8'h00;
    end else begin
      abort      <= 1'b0;
      op_start   <= 1'b0;
      reset_busy <= (rcv_ff != 12'd0);
      if (rcv_ff != 12'd0)
        rcv_ff <= rcv_ff - 12'd1;
      if (frame_end && rcv_ff == 12'd0 && (ph_ff != PH_CMD ||
          cnt_ff != 6'd0)) begin
        arm_ff     <= (ph_ff == PH_END) && (op_ff == `OP_RARM);
        vol_arm_ff <= (ph_ff == PH_END) && (op_ff == `OP_VWREN);
        if (op_ff == `OP_QIO && ph_ff == PH_OUT)
          enhanced <= (ind_ff[7:4] == `ENH_IND);
        if (ph_ff == PH_END) begin
          case (op_ff)
            `OP_QENTRY: quad_command_mode <= 1'b1;
            `OP_QEXIT: begin
              if (enhanced)
                enhanced <= 1'b0;
              else
                quad_command_mode <= 1'b0;
            end
            `OP_WRITE_ENABLE_CMD: write_enable_latch <= 1'b1;
            `OP_WRITE_DISABLE_CMD: begin
              write_enable_latch <= 1'b0;
              otp_mode           <= 1'b0;
            end
            `OP_OTP: otp_mode <= 1'b1;
            `OP_REXEC: begin
              if (arm_ff && !deep_pd) begin
                quad_command_mode  <= 1'b0;
                enhanced           <= 1'b0;
                otp_mode           <= 1'b0;
                write_enable_latch <= 1'b0;
                vol_ovr_ff         <= 1'b0;
                abort              <= busy_in;
                // Only an interrupted cycle needs the long recovery.
                rcv_ff <= busy_in ? RECOV_CYC : 12'd1;
              end
            end
            `OP_STATUS_WRITE_CMD: begin
              if (vol_arm_ff) begin
                vol_ff     <= wr_byte[7:2];
                vol_ovr_ff <= 1'b1;
              end else if (write_enable_latch && !busy_in) begin
                op_start <= 1'b1;
                op_code  <= op_ff;
              end
            end
            default: begin
              if ((is_erase || is_ce) && write_enable_latch && !busy_in) begin
                op_start <= 1'b1;
                op_code  <= op_ff;
              end
            end
          endcase
        end
        if (is_prog && ph_ff == PH_DIN && got_data_ff &&
            write_enable_latch && !busy_in) begin
          op_start <= 1'b1;
          op_code  <= op_ff;
        end
      end
      // Completion stands last so it wins over a same-cycle enable.
      if (op_done)
        write_enable_latch <= 1'b0;
    end
  end

endmodule // serial_flash_command_decoder

`default_nettype wire

// File: hdl/sflash_consts.vh
// Opcodes, widths and timing counts for the serial flash command decoder.
`ifndef SFLASH_CONSTS_VH
`define SFLASH_CONSTS_VH

// Read opcodes.
`define OP_READ    8'h03
`define OP_FAST    8'h0B
`define OP_DOUT    8'h3B
`define OP_DIO     8'hBB
`define OP_QOUT    8'h6B
`define OP_QIO     8'hEB

// Mode, reset and latch opcodes.
`define OP_QENTRY  8'h38
`define OP_QEXIT   8'hFF
`define OP_RARM    8'h66
`define OP_REXEC   8'h99
`define OP_WRITE_ENABLE_CMD    8'h06
`define OP_VWREN   8'h50
`define OP_WRITE_DISABLE_CMD    8'h04
`define OP_OTP     8'h3A

// Status and identification opcodes.
`define OP_STATUS_READ_CMD    8'h05
`define OP_STATUS_WRITE_CMD    8'h01
`define OP_RDID    8'h9F

// Program and erase opcodes.
`define OP_PP      8'h02
`define OP_QPP     8'h32
`define OP_SE      8'h20
`define OP_HBE     8'h52
`define OP_BE      8'hD8
`define OP_CE1     8'hC7
`define OP_CE2     8'h60

// Bit counts and dummy clock counts.
`define ADDR_BITS  6'd24
`define BYTE_BITS  6'd8
`define DUM_SINGLE 4'd8
`define DUM_QUAD   4'd6
`define DUM_DIO    4'd4
`define DUM_QIO    4'd6
`define IND_CLKS   4'd2

// Enhance indicator nibble that keeps the continuous quad read alive.
`define ENH_IND    4'hA

// Status byte field positions and reset value.
`define SR_BUSY    0
`define SR_WEL     1
`define SR_RESET   8'h00

// Timing: core clock period and worst software reset latency.
`define T_CLK_NS       10
`define T_RST_RECOV_NS 28000
`define RST_RECOV_CYC  (`T_RST_RECOV_NS / `T_CLK_NS)

`endif

// File: hdl/pin_sync.v
// Three-stage synchroniser with agreement filter for link pins.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter       W       = 6,
  parameter [5:0] RST_VAL = 6'h00
) (
  input  wire         core_clk,
  input  wire         rstn,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  // The first stage feeds only the second; a bit changes once two agree.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= RST_VAL[W-1:0];
      s2_ff <= RST_VAL[W-1:0];
      s3_ff <= RST_VAL[W-1:0];
      q_out <= RST_VAL[W-1:0];
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_out <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_out & (s2_ff ^ s3_ff));
    end
  end

endmodule // pin_sync

`default_nettype wire

// File: sim/flash_decoder_assertions.sv
// Concurrent checks on the serial flash command decoder's ports.
`timescale 1ns/10ps
`default_nettype none
`include "sflash_consts.vh"
module flash_decoder_checker (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       cs_n_pin,
  input wire logic       busy_in,
  input wire logic       op_done,
  input wire logic [3:0] dq_oe,
  input wire logic       op_start,
  input wire logic       abort,
  input wire logic       quad_command_mode,
  input wire logic       enhanced,
  input wire logic       otp_mode,
  input wire logic       write_enable_latch,
  input wire logic       reset_busy
);
  localparam int RECOV_MAX = `RST_RECOV_CYC;
  logic [12:0] recov_cnt_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Recovery length counter; a stuck recovery would lock out the host.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) recov_cnt_ff <= 13'h0000;
    else if (reset_busy) recov_cnt_ff <= recov_cnt_ff + 13'h0001;
    else recov_cnt_ff <= 13'h0000;
  end

  // Completion of an array cycle drops the latch.
  property p_latch_clear;
    op_done |=> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latch still set after completion");
  // A starting reset recovery finds every mode and the latch cleared.
  property p_reset_state;
    $rose(reset_busy) |-> !quad_command_mode && !enhanced && !otp_mode
      && !write_enable_latch;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("mode kept across reset");
  property p_abort_cause;
    abort |-> $past(busy_in) ##1 !abort;
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without busy or too long");
  property p_recov_hold;
    $rose(abort) |-> ##[0:2] reset_busy [*8];
  endproperty
  a_recov_hold: assert property (p_recov_hold)
    else $error("no long recovery after abort");
  property p_recov_bound;
    recov_cnt_ff <= RECOV_MAX;
  endproperty
  a_recov_bound: assert property (p_recov_bound)
    else $error("recovery too long");
  property p_start_gate;
    op_start |-> $past(write_enable_latch) && !$past(busy_in);
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("array op started without latch");
  property p_quad_deselect;
    $changed(quad_command_mode) |-> $past(cs_n_pin, 3);
  endproperty
  a_quad_deselect: assert property (p_quad_deselect)
    else $error("mode changed inside a frame");
  property p_wel_deselect;
    $rose(write_enable_latch) |-> $past(cs_n_pin, 3);
  endproperty
  a_wel_deselect: assert property (p_wel_deselect)
    else $error("latch set inside a frame");
  property p_oe_idle;
    cs_n_pin [*8] |-> dq_oe == 4'h0;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("driving while deselected");
  property p_oe_shape;
    dq_oe != 4'h0 |-> dq_oe inside {4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_shape: assert property (p_oe_shape)
    else $error("illegal output lane set");
endmodule // flash_decoder_checker

bind serial_flash_command_decoder flash_decoder_checker u_chk (
  .core_clk, .rstn, .cs_n_pin, .busy_in, .op_done, .dq_oe, .op_start,
  .abort, .quad_command_mode, .enhanced, .otp_mode, .write_enable_latch,
  .reset_busy);
`default_nettype wire

// File: sim/spi_host.sv
// Host link controller model that clocks frames into the decoder.
`timescale 1ns/10ps
`default_nettype none
module spi_host (
  output var logic        sck,
  output var logic        cs_n,
  output wire logic [3:0] dq_in,
  input  wire logic [3:0] dq_out,
  input  wire logic [3:0] dq_oe
);
  logic [3:0] drv;

  // Wire level: the device wins on every lane it enables.
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & drv);

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
  end

  // One mode 0 clock; data is set while low, sampled before the rise.
  task automatic clk1(input logic [3:0] d, output logic [3:0] q);
    drv = d;
    #63;
    q = dq_in;
    sck = 1'b1;
    #62;
    sck = 1'b0;
  endtask
  // Unused lanes toggle so a stale level is never mistaken for data.
  task automatic tx(input logic [7:0] b, input int w);
    logic [3:0] q, m;
    m = 4'((1 << w) - 1);
    for (int i = 8 - w; i >= 0; i -= w)
      clk1((~drv & ~m) | (4'(b >> i) & m), q);
  endtask
  task automatic rx(output logic [7:0] b, input int w);
    logic [3:0] q, m;
    m = 4'((1 << w) - 1);
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      clk1(~drv, q);
      b = (b << w) | 8'((w == 1) ? q[1] : q & m);
    end
  endtask
  task automatic dummy1();
    logic [3:0] q;
    clk1(~drv, q);
  endtask
  // Each opcode gets a frame of its own; the clock rests between.
  task automatic start();
    cs_n = 1'b0;
    #100;
  endtask
  task automatic stop();
    #100;
    cs_n = 1'b1;
    drv = ~drv;
    #300;
  endtask
endmodule // spi_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the serial flash command decoder.
`timescale 1ns/10ps
`default_nettype none
`include "sflash_consts.vh"
module testbench;
  localparam logic [23:0] ADR = 24'h00_1234;
  logic             core_clk, rstn, busy_in, op_done, deep_pd;
  logic [5:0]       nv_status;
  logic [7:0]       mem_rd_data, b;
  wire logic        sck, cs_n, mem_rd_req, op_start, abort;
  wire logic        quad_command_mode, write_enable_latch, reset_busy;
  wire logic        enhanced, otp_mode, wr_byte_valid;
  wire logic [3:0]  dq_in, dq_out, dq_oe;
  wire logic [23:0] mem_rd_addr, op_addr;
  wire logic [7:0]  op_code, wr_byte;
  int               n_errors, total_checks, n_starts, n_rd, n_abort;
  int               n_rb, n_wv, cyc, k;
  logic [7:0]       rq [5] = '{8'h03, 8'h3B, 8'hBB, 8'h6B, 8'h32};

  // Identity bytes are arbitrary values.
  serial_flash_command_decoder #(.MFR_ID(8'hA1), .MEM_TYPE(8'hB2),
    .MEM_CAP(8'hC3)) dut (
    .core_clk, .rstn, .sck_pin(sck), .cs_n_pin(cs_n), .dq_in, .dq_out,
    .dq_oe, .busy_in, .op_done, .nv_status, .deep_pd, .mem_rd_data,
    .mem_rd_req, .mem_rd_addr, .op_start, .op_code, .op_addr,
    .wr_byte, .wr_byte_valid, .abort, .quad_command_mode,
    .enhanced, .otp_mode, .write_enable_latch, .reset_busy);
  spi_host host (.sck, .cs_n, .dq_in, .dq_out, .dq_oe);

  always #5 core_clk = ~core_clk;

  // Array model, pulse tallies and the hang guard.
  always @(posedge core_clk) begin
    mem_rd_data <= #1 mem_rd_addr[7:0] ^ 8'hC3;
    if (op_start === 1'b1) n_starts++;
    if (mem_rd_req === 1'b1) n_rd++;
    if (abort === 1'b1) n_abort++;
    if (reset_busy === 1'b1) n_rb++;
    if (wr_byte_valid === 1'b1) n_wv++;
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic drv_in(input logic bz, od, dp);
    @(posedge core_clk);
    #1 busy_in = bz;
    op_done = od;
    deep_pd = dp;
  endtask
  task automatic cmd(input logic [7:0] op, input int w);
    host.start();
    host.tx(op, w);
    host.stop();
  endtask
  task automatic frame2(input logic [7:0] op, d);
    host.start();
    host.tx(op, 1);
    host.tx(d, 1);
    host.stop();
  endtask
  // Opcode, optional address, dummies, then n reply bytes compared.
  task automatic rdf(input logic [7:0] op, input int cw, aw, nd, dw,
                     input logic [23:0] e, input int n);
    host.start();
    host.tx(op, cw);
    for (int i = 16; aw > 0 && i >= 0; i -= 8) host.tx(ADR[i+:8], aw);
    repeat (nd) host.dummy1();
    for (int i = 0; i < n; i++) begin
      host.rx(b, dw);
      chk(b, e[23-8*i-:8]);
    end
    host.stop();
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Status bytes below are the stored bits 2D above latch and busy, except FE after the volatile write.
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    busy_in = 1'b0;
    op_done = 1'b0;
    deep_pd = 1'b0;
    nv_status = 6'h2D;
    mem_rd_data = 8'h00;
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge core_clk);
    rdf(8'h05, 1, 0, 0, 1, 24'hB4_B400, 2);
    cmd(8'h50, 1);
    chk(write_enable_latch, 0);
    cmd(8'h06, 1);
    chk(write_enable_latch, 1);
    drv_in(1, 0, 0);
    rdf(8'h05, 1, 0, 0, 1, 24'hB7_0000, 1);
    drv_in(0, 0, 0);
    cmd(8'h3A, 1);
    chk(otp_mode, 1);
    cmd(8'h04, 1);
    chk(write_enable_latch, 0);
    chk(otp_mode, 0);
    frame2(8'h01, 8'h3C);
    chk(n_starts, 0);
    cmd(8'h06, 1);
    frame2(8'h01, 8'h3C);
    chk(n_starts, 1);
    chk(op_code, 8'h01);
    drv_in(0, 1, 0);
    drv_in(0, 0, 0);
    chk(write_enable_latch, 0);
    // Program: eight toggling data clocks after the address form AA.
    cmd(8'h06, 1);
    rdf(8'h02, 1, 1, 8, 1, 24'h00_0000, 0);
    chk(n_starts, 2);
    chk(op_code, 8'h02);
    chk(op_addr, ADR);
    chk(wr_byte, 8'hAA);
    chk(n_wv, 1);
    drv_in(0, 1, 0);
    drv_in(0, 0, 0);
    rdf(8'h9F, 1, 0, 0, 1, 24'hA1_B2C3, 3);
    rdf(8'h03, 1, 1, 0, 1, 24'hF7_0000, 1);
    rdf(8'h0B, 1, 1, 8, 1, 24'hF7_0000, 1);
    rdf(8'h3B, 1, 1, 8, 2, 24'hF7_F600, 2);
    rdf(8'h6B, 1, 1, 8, 4, 24'hF7_F600, 2);
    rdf(8'hEB, 1, 4, 6, 4, 24'hF7_0000, 1);
    cmd(8'h38, 1);
    chk(quad_command_mode, 1);
    rdf(8'h0B, 4, 4, 6, 4, 24'hF7_0000, 1);
    k = n_rd;
    foreach (rq[i]) rdf(rq[i], 4, 4, 4, 4, 24'h00_0000, 0);
    chk(n_rd, k);
    // Quad address read whose first two dummy clocks carry indicator A.
    host.start();
    host.tx(8'hEB, 4);
    for (k = 16; k >= 0; k -= 8) host.tx(ADR[k+:8], 4);
    host.tx(8'hA5, 4);
    repeat (4) host.dummy1();
    host.rx(b, 4);
    chk(b, 8'hF7);
    host.stop();
    chk(enhanced, 1);
    cmd(8'hFF, 4);
    chk(enhanced, 0);
    chk(quad_command_mode, 1);
    cmd(8'hFF, 4);
    chk(quad_command_mode, 0);
    cmd(8'hFF, 1);
    rdf(8'h05, 1, 0, 0, 1, 24'hB4_0000, 1);
    cmd(8'h06, 1);
    cmd(8'h66, 1);
    cmd(8'h05, 1);
    cmd(8'h99, 1);
    chk(write_enable_latch, 1);
    cmd(8'h50, 1);
    frame2(8'h01, 8'hFC);
    rdf(8'h05, 1, 0, 0, 1, 24'hFE_0000, 1);
    cmd(8'h66, 1);
    cmd(8'h99, 1);
    chk(write_enable_latch, 0);
    rdf(8'h05, 1, 0, 0, 1, 24'hB4_0000, 1);
    cmd(8'h38, 1);
    cmd(8'h66, 4);
    cmd(8'h99, 4);
    chk(quad_command_mode, 0);
    cmd(8'h06, 1);
    drv_in(0, 0, 1);
    cmd(8'h66, 1);
    cmd(8'h99, 1);
    chk(write_enable_latch, 1);
    drv_in(1, 0, 0);
    cmd(8'h66, 1);
    k = n_rb;
    cmd(8'h99, 1);
    drv_in(0, 0, 0);
    repeat (3000) @(posedge core_clk);
    chk(n_abort, 1);
    chk(n_rb - k >= 2700 && n_rb - k <= `RST_RECOV_CYC, 1);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
